// [rtl/cdcw_map.svh]
// Opcode, field and reset constants for the decrement, complement and watchdog-clear decoder
`ifndef CDCW_MAP_SVH
`define CDCW_MAP_SVH

// Instruction word fields
`define CDCW_INSTR_W 14
`define CDCW_OP_MSB 13
`define CDCW_OP_LSB 8
`define CDCW_DEST_BIT 7
`define CDCW_ADDR_MSB 6
`define CDCW_ADDR_LSB 0

// Opcodes in the upper six bits
`define CDCW_OP_DEC 6'h03
`define CDCW_OP_COM 6'h09
`define CDCW_OP_DSZ 6'h0B

// Whole word of the watchdog clear operation
`define CDCW_WDT_CLR_WORD 14'h0064

// Reset values and watchdog clear values
`define CDCW_FLAG_N_RST 1'h1
`define CDCW_ZERO_RST 1'h0
`define CDCW_W_RST 8'h00
`define CDCW_WDT_RST 8'h00
`define CDCW_PRE_RST 8'h00
`define CDCW_WDT_CLR_VAL 8'h00
`define CDCW_PRE_CLR_VAL 8'h00

`endif

// [rtl/cdcw_pkg.sv]
// Types shared by the decoder core and its file register memory
package cdcw_pkg;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_READ,
      ST_EXEC,
      ST_SKIP
   } cdcw_state_e;

   typedef enum logic [2:0] {
      OP_NONE,
      OP_DEC,
      OP_COM,
      OP_DSZ,
      OP_WDT
   } cdcw_op_e;

   typedef struct packed {
      logic we;
      logic [6:0] addr;
      logic [7:0] data;
   } cdcw_file_wr_s;

   typedef struct packed {
      cdcw_state_e st;
      logic [13:0] instr;
      logic [6:0] rd_addr;
      logic [7:0] w;
      logic zero;
      logic to_n;
      logic pd_n;
      logic ready;
      logic wdt_clr;
      logic skip;
      logic done;
      logic ignored;
      logic [7:0] wdt_cnt;
      logic [7:0] wdt_pre;
      logic [2:0] sync;
      logic tick_lvl;
      cdcw_file_wr_s wr;
   } cdcw_state_s;

endpackage

// [rtl/cdcw_regfile.sv]
// File register memory: one registered read port, core write with priority over loader
`timescale 1ns/1ns
module cdcw_regfile #(
   parameter int DEPTH = 128
) (
   // Clock
   input wire logic clk,
   // Read port
   input wire logic [6:0] rd_addr,
   output logic [7:0] rd_data,
   // Write ports
   input wire cdcw_pkg::cdcw_file_wr_s core_wr,
   input wire cdcw_pkg::cdcw_file_wr_s load_wr
);

   logic [7:0] mem [DEPTH];

   // Core write wins so an executing instruction never loses its result
   always_ff @(posedge clk) begin
      if (core_wr.we) begin
         mem[core_wr.addr] <= core_wr.data;
      end else if (load_wr.we) begin
         mem[load_wr.addr] <= load_wr.data;
      end
      rd_data <= mem[rd_addr];
   end

endmodule // cdcw_regfile

// [rtl/cdcw_core.sv]
// Decode and execute of watchdog clear, decrement, complement and decrement-skip-zero
`timescale 1ns/1ns
`include "cdcw_map.svh"

module cdcw_core (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Instruction issue
   input wire logic instr_valid,
   input wire logic [13:0] instr,
   output logic instr_ready,
   // Register file loader
   input wire cdcw_pkg::cdcw_file_wr_s load_wr,
   // Watchdog oscillator tick pin
   input wire logic wdt_tick_pin,
   // Core state
   output logic [7:0] work_reg,
   output logic zero_flag,
   output logic timeout_flag_n,
   output logic powerdown_flag_n,
   // Watchdog state
   output logic [7:0] watchdog_counter,
   output logic [7:0] watchdog_prescale,
   // Event pulses
   output logic wdt_clear_pulse,
   output logic skip_pulse,
   output logic done_pulse,
   output logic ignored_pulse,
   // File register write
   output cdcw_pkg::cdcw_file_wr_s file_wr
);

   cdcw_pkg::cdcw_state_s s_q;
   cdcw_pkg::cdcw_state_s s_d;
   logic [7:0] rd_data;

   // Field split and opcode classification, used at issue and at execute
   function automatic cdcw_pkg::cdcw_op_e decode(input logic [13:0] iw);
      logic [5:0] op;
      op = iw[`CDCW_OP_MSB:`CDCW_OP_LSB];
      if (iw == `CDCW_WDT_CLR_WORD) begin
         decode = cdcw_pkg::OP_WDT;
      end else if (op == `CDCW_OP_DEC) begin
         decode = cdcw_pkg::OP_DEC;
      end else if (op == `CDCW_OP_COM) begin
         decode = cdcw_pkg::OP_COM;
      end else if (op == `CDCW_OP_DSZ) begin
         decode = cdcw_pkg::OP_DSZ;
      end else begin
         decode = cdcw_pkg::OP_NONE;
      end
   endfunction

   cdcw_pkg::cdcw_op_e exec_op;
   logic [7:0] result;
   logic accept;

   assign exec_op = decode(s_q.instr);
   assign accept = instr_valid && s_q.ready;
   // Complement inverts, both decrement forms subtract one
   assign result = (exec_op == cdcw_pkg::OP_COM) ? ~rd_data : rd_data - 8'h01;

   // Operand memory; its read data come one cycle after the address
   cdcw_regfile #(
      .DEPTH(128)
   ) u_regfile (
      .clk(clk),
      .rd_addr(s_q.rd_addr),
      .rd_data(rd_data),
      .core_wr(s_q.wr),
      .load_wr(load_wr)
   );

   // Next state of the whole block
   always_comb begin
      s_d = s_q;
      s_d.wdt_clr = 1'b0;
      s_d.skip = 1'b0;
      s_d.done = 1'b0;
      s_d.ignored = 1'b0;
      s_d.wr.we = 1'b0;
      // Three-stage pin sync; only stages two and three decide a level change
      s_d.sync = {s_q.sync[1:0], wdt_tick_pin};
      if (s_q.sync[1] == s_q.sync[2]) begin
         s_d.tick_lvl = s_q.sync[2];
      end
      // Prescaler advances on each accepted rising tick, counter on its wrap
      if (s_d.tick_lvl && !s_q.tick_lvl) begin
         s_d.wdt_pre = s_q.wdt_pre + 8'h01;
         if (s_q.wdt_pre == 8'hFF) begin
            s_d.wdt_cnt = s_q.wdt_cnt + 8'h01;
            if (s_q.wdt_cnt == 8'hFF) begin
               s_d.to_n = 1'b0; // Timeout drops when the counter runs out
            end
         end
      end
      case (s_q.st)
         cdcw_pkg::ST_IDLE: begin
            if (accept) begin
               if (decode(instr) == cdcw_pkg::OP_WDT) begin
                  // Clear beats a tick arriving in the same cycle
                  s_d.wdt_cnt = `CDCW_WDT_CLR_VAL;
                  s_d.wdt_pre = `CDCW_PRE_CLR_VAL;
                  s_d.to_n = 1'b1;
                  s_d.pd_n = 1'b1;
                  s_d.wdt_clr = 1'b1;
                  s_d.done = 1'b1;
               end else if (decode(instr) == cdcw_pkg::OP_NONE) begin
                  s_d.ignored = 1'b1;
               end else begin
                  s_d.instr = instr;
                  s_d.rd_addr = instr[`CDCW_ADDR_MSB:`CDCW_ADDR_LSB];
                  s_d.ready = 1'b0;
                  s_d.st = cdcw_pkg::ST_READ;
               end
            end
         end
         cdcw_pkg::ST_READ: begin
            s_d.st = cdcw_pkg::ST_EXEC;
         end
         cdcw_pkg::ST_EXEC: begin
            // Destination bit picks W or the register itself
            if (s_q.instr[`CDCW_DEST_BIT]) begin
               s_d.wr.we = 1'b1;
               s_d.wr.addr = s_q.rd_addr;
               s_d.wr.data = result;
            end else begin
               s_d.w = result;
            end
            if (exec_op == cdcw_pkg::OP_DSZ) begin
               // Flags untouched; a zero result burns the prefetched word
               if (result == 8'h00) begin
                  s_d.skip = 1'b1;
                  s_d.st = cdcw_pkg::ST_SKIP;
               end else begin
                  s_d.done = 1'b1;
                  s_d.ready = 1'b1;
                  s_d.st = cdcw_pkg::ST_IDLE;
               end
            end else begin
               s_d.zero = (result == 8'h00);
               s_d.done = 1'b1;
               s_d.ready = 1'b1;
               s_d.st = cdcw_pkg::ST_IDLE;
            end
         end
         cdcw_pkg::ST_SKIP: begin
            // No-operation cycle standing in for the discarded word
            s_d.done = 1'b1;
            s_d.ready = 1'b1;
            s_d.st = cdcw_pkg::ST_IDLE;
         end
         default: begin
            s_d.ready = 1'b1;
            s_d.st = cdcw_pkg::ST_IDLE;
         end
      endcase
   end

   // State register
   always_ff @(posedge clk) begin
      if (rst) begin
         s_q <= '0;
         s_q.st <= cdcw_pkg::ST_IDLE;
         s_q.w <= `CDCW_W_RST;
         s_q.zero <= `CDCW_ZERO_RST;
         s_q.to_n <= `CDCW_FLAG_N_RST;
         s_q.pd_n <= `CDCW_FLAG_N_RST;
         s_q.ready <= 1'b1;
         s_q.wdt_cnt <= `CDCW_WDT_RST;
         s_q.wdt_pre <= `CDCW_PRE_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs straight from the state register
   assign instr_ready = s_q.ready;
   assign work_reg = s_q.w;
   assign zero_flag = s_q.zero;
   assign timeout_flag_n = s_q.to_n;
   assign powerdown_flag_n = s_q.pd_n;
   assign watchdog_counter = s_q.wdt_cnt;
   assign watchdog_prescale = s_q.wdt_pre;
   assign wdt_clear_pulse = s_q.wdt_clr;
   assign skip_pulse = s_q.skip;
   assign done_pulse = s_q.done;
   assign ignored_pulse = s_q.ignored;
   assign file_wr = s_q.wr;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   logic in_exec;
   assign in_exec = (s_q.st == cdcw_pkg::ST_EXEC);

   property p_wdt_cnt_clr;
      accept && instr == `CDCW_WDT_CLR_WORD |=> watchdog_counter == 8'h00 && wdt_clear_pulse;
   endproperty
   a_wdt_cnt_clr: assert property (p_wdt_cnt_clr) else $error("watchdog counter not cleared");

   property p_wdt_pre_clr;
      accept && instr == `CDCW_WDT_CLR_WORD |=> watchdog_prescale == 8'h00 && instr_ready;
   endproperty
   a_wdt_pre_clr: assert property (p_wdt_pre_clr) else $error("prescaler not cleared");

   property p_wdt_flags;
      accept && instr == `CDCW_WDT_CLR_WORD
         |=> timeout_flag_n && powerdown_flag_n && $stable(zero_flag) && $stable(work_reg);
   endproperty
   a_wdt_flags: assert property (p_wdt_flags) else $error("status after watchdog clear wrong");

   property p_dec;
      in_exec && exec_op == cdcw_pkg::OP_DEC && !s_q.instr[7]
         |=> work_reg == $past(rd_data) - 8'h01 && zero_flag == (work_reg == 8'h00) && done_pulse;
   endproperty
   a_dec: assert property (p_dec) else $error("decrement to W wrong");

   property p_com;
      in_exec && exec_op == cdcw_pkg::OP_COM && s_q.instr[7]
         |=> file_wr.we && file_wr.data == ~$past(rd_data) && zero_flag == (file_wr.data == 8'h00);
   endproperty
   a_com: assert property (p_com) else $error("complement to register wrong");

   property p_dsz_flags;
      in_exec && exec_op == cdcw_pkg::OP_DSZ |=> $stable(zero_flag) && $stable(timeout_flag_n);
   endproperty
   a_dsz_flags: assert property (p_dsz_flags) else $error("skip op changed a flag");

   property p_skip;
      in_exec && exec_op == cdcw_pkg::OP_DSZ && rd_data == 8'h01 |=> skip_pulse && !instr_ready;
   endproperty
   a_skip: assert property (p_skip) else $error("zero result did not skip");

   property p_skip_len;
      skip_pulse |-> !instr_ready ##1 (instr_ready && done_pulse && !skip_pulse);
   endproperty
   a_skip_len: assert property (p_skip_len) else $error("skip cycle count wrong");

   property p_noskip;
      in_exec && exec_op == cdcw_pkg::OP_DSZ && rd_data != 8'h01 |=> instr_ready && !skip_pulse;
   endproperty
   a_noskip: assert property (p_noskip) else $error("non-zero result skipped");

   property p_fields;
      accept && decode(instr) == cdcw_pkg::OP_DEC |=> s_q.rd_addr == $past(instr[6:0]) ##2 done_pulse;
   endproperty
   a_fields: assert property (p_fields) else $error("operand field or timing wrong");

   c_wdt: cover property (accept && instr == `CDCW_WDT_CLR_WORD);
   c_skip: cover property (skip_pulse ##1 done_pulse);
   c_com_w: cover property (in_exec && exec_op == cdcw_pkg::OP_COM && !s_q.instr[7]);
   c_dec_f: cover property (in_exec && exec_op == cdcw_pkg::OP_DEC && s_q.instr[7]);

endmodule // cdcw_core

// [testbench/tb_cpu_decrement_complement_wdt_ops.sv]
// Self-checking bench for the decrement, complement and watchdog clear decoder
`timescale 1ns/1ns
`include "cdcw_map.svh"
module tb_cpu_decrement_complement_wdt_ops;
   // Stimulus and observed signals
   logic clk;
   logic rst;
   logic instr_valid;
   logic [13:0] instr;
   logic instr_ready;
   cdcw_pkg::cdcw_file_wr_s load_wr;
   logic wdt_tick_pin;
   logic [7:0] work_reg;
   logic zero_flag;
   logic timeout_flag_n;
   logic powerdown_flag_n;
   logic [7:0] watchdog_counter;
   logic [7:0] watchdog_prescale;
   logic wdt_clear_pulse;
   logic skip_pulse;
   logic done_pulse;
   logic ignored_pulse;
   cdcw_pkg::cdcw_file_wr_s file_wr;
   // Bookkeeping
   int n_fail = 0;
   int comparisons = 0;
   int cycles = 0;
   int done_at;
   int skip_at;
   int ign_at;
   cdcw_pkg::cdcw_file_wr_s wr_seen;

   cdcw_core dut (
      .clk(clk),
      .rst(rst),
      .instr_valid(instr_valid),
      .instr(instr),
      .instr_ready(instr_ready),
      .load_wr(load_wr),
      .wdt_tick_pin(wdt_tick_pin),
      .work_reg(work_reg),
      .zero_flag(zero_flag),
      .timeout_flag_n(timeout_flag_n),
      .powerdown_flag_n(powerdown_flag_n),
      .watchdog_counter(watchdog_counter),
      .watchdog_prescale(watchdog_prescale),
      .wdt_clear_pulse(wdt_clear_pulse),
      .skip_pulse(skip_pulse),
      .done_pulse(done_pulse),
      .ignored_pulse(ignored_pulse),
      .file_wr(file_wr)
   );

   // 125 MHz clock
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // Hang guard: the watchdog ticks make the run about 2400 cycles long
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 4000) begin
         n_fail = n_fail + 1;
         tally_and_finish();
      end
   end

   task automatic tally_and_finish();
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // Four-state compare so an unknown never matches
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   // Preload one file register; the core is idle so the loader is not overruled
   task automatic load(input logic [6:0] a, input logic [7:0] d);
      @(negedge clk);
      load_wr = {1'b1, a, d};
      @(negedge clk);
      load_wr.we = 1'b0;
   endtask

   // Issue one word, then note the cycle of skip, done and any file write
   task automatic exec(input logic [13:0] w);
      @(negedge clk);
      instr = w;
      instr_valid = 1'b1;
      @(negedge clk);
      instr_valid = 1'b0;
      done_at = 0;
      skip_at = 0;
      ign_at = 0;
      wr_seen = '0;
      for (int n = 1; n < 10 && done_at == 0; n++) begin
         if (n > 1) @(negedge clk);
         if (skip_pulse === 1'b1) skip_at = n;
         if (ignored_pulse === 1'b1) ign_at = n;
         if (file_wr.we === 1'b1) wr_seen = file_wr;
         if (done_pulse === 1'b1) done_at = n;
      end
   endtask

   task automatic t_dec();
      load(7'h05, 8'h01);
      exec({`CDCW_OP_DEC, 1'b1, 7'h05});
      chk("dec cycles", 16'h3, done_at[15:0]);
      chk("dec write", {1'b1, 7'h05, 8'h00}, wr_seen);
      chk("dec zero", 16'h1, zero_flag);
      // Reading back through W proves the memory took the write
      exec({`CDCW_OP_DEC, 1'b0, 7'h05});
      chk("dec w", 16'hFF, work_reg);
      chk("dec w no write", 16'h0, wr_seen.we);
      chk("dec zero clear", 16'h0, zero_flag);
   endtask

   task automatic t_com();
      load(7'h07, 8'h13);
      exec({`CDCW_OP_COM, 1'b0, 7'h07});
      chk("com w", 16'hEC, work_reg);
      chk("com w no write", 16'h0, wr_seen.we);
      load(7'h08, 8'hFF);
      exec({`CDCW_OP_COM, 1'b1, 7'h08});
      chk("com write", {1'b1, 7'h08, 8'h00}, wr_seen);
      chk("com zero", 16'h1, zero_flag);
      exec({`CDCW_OP_COM, 1'b0, 7'h08});
      chk("com back", 16'hFF, work_reg);
      chk("com zero clear", 16'h0, zero_flag);
   endtask

   task automatic t_dsz();
      load(7'h09, 8'h02);
      load(7'h0B, 8'h01);
      load(7'h0C, 8'h01);
      exec({`CDCW_OP_DSZ, 1'b0, 7'h09});
      chk("dsz w", 16'h01, work_reg);
      chk("dsz cycles", 16'h3, done_at[15:0]);
      chk("dsz no skip", 16'h0, skip_at[15:0]);
      // Zero result with the flag low: the flag must stay low
      exec({`CDCW_OP_DSZ, 1'b1, 7'h0B});
      chk("dsz skip", 16'h3, skip_at[15:0]);
      chk("dsz skip cycles", 16'h4, done_at[15:0]);
      chk("dsz write", {1'b1, 7'h0B, 8'h00}, wr_seen);
      chk("dsz zero kept", 16'h0, zero_flag);
      // Nonzero result with the flag high: the flag must stay high
      exec({`CDCW_OP_DEC, 1'b1, 7'h0C});
      exec({`CDCW_OP_DSZ, 1'b0, 7'h0C});
      chk("dsz wrap", 16'hFF, work_reg);
      chk("dsz zero held", 16'h1, zero_flag);
      chk("dsz wrap no skip", 16'h0, skip_at[15:0]);
   endtask

   // A word outside the four operations is dropped without a result
   task automatic t_ign();
      exec(14'h0100);
      chk("ign pulse", 16'h1, ign_at[15:0]);
      chk("ign no done", 16'h0, done_at[15:0]);
      chk("ign no write", 16'h0, wr_seen.we);
      chk("ign ready", 16'h1, instr_ready);
   endtask

   task automatic t_wdt();
      // 259 pin pulses: one prescaler wrap steps the counter, so the clear has work to do
      for (int i = 0; i < 259; i++) begin
         @(negedge clk);
         wdt_tick_pin = 1'b1;
         repeat (4) @(negedge clk);
         wdt_tick_pin = 1'b0;
         repeat (4) @(negedge clk);
      end
      chk("prescale", 16'h3, watchdog_prescale);
      chk("counter", 16'h1, watchdog_counter);
      exec(`CDCW_WDT_CLR_WORD);
      chk("clr cycles", 16'h1, done_at[15:0]);
      chk("clr pulse", 16'h1, wdt_clear_pulse);
      chk("clr counter", 16'h0, watchdog_counter);
      chk("clr prescale", 16'h0, watchdog_prescale);
      chk("clr flags", 16'h3, {timeout_flag_n, powerdown_flag_n});
      chk("clr zero kept", 16'h1, zero_flag);
      chk("clr w kept", 16'hFF, work_reg);
      chk("clr ready", 16'h1, instr_ready);
   endtask

   // Main sequence
   initial begin
      rst = 1'b1;
      instr_valid = 1'b0;
      instr = '0;
      load_wr = '0;
      wdt_tick_pin = 1'b0;
      repeat (8) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      chk("rst ready", 16'h1, instr_ready);
      chk("rst w", 16'h0, work_reg);
      chk("rst flags", 16'h3, {zero_flag, timeout_flag_n, powerdown_flag_n});
      t_dec();
      t_com();
      t_dsz();
      t_ign();
      t_wdt();
      tally_and_finish();
   end
endmodule // tb_cpu_decrement_complement_wdt_ops
